// ---- rtl/async_pipe_handler.sv ----
// response handler for bulk and control pipes of a superspeed host schedule
// assumes responses already decoded from the link; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "async_pipe_defs.svh"

module async_pipe_handler (
  input wire logic clock, // 200 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic resp_valid, // decoded response offered
  output logic resp_ready, // response queue has room
  input wire pipe_resp_pkg::resp_type resp, // decoded response
  input wire logic td_load, // new descriptor for td_ep
  input wire logic [`EP_BITS-1:0] td_ep, // endpoint of new descriptor
  input wire logic [`SIZE_BITS-1:0] td_size, // descriptor transfer size
  input wire logic halt_clear, // release halted endpoint
  input wire logic [`EP_BITS-1:0] halt_clear_ep, // endpoint to release
  input wire logic [`EP_COUNT-1:0] ep_dir_in, // per endpoint, 1 = IN
  input wire logic [`EP_COUNT-1:0] ring_empty, // per endpoint transfer ring empty
  input wire logic [`MPS_BITS-1:0] max_packet_size, // bytes per full packet
  input wire logic [`BUDGET_BITS-1:0] max_opportunity_packets, // packets per opportunity
  output pipe_resp_pkg::request_type request, // transaction to issue, pulse
  output pipe_resp_pkg::action_type action, // decision taken, pulse
  output logic [`EP_COUNT-1:0] sched, // endpoints on the schedule
  output logic [`EP_COUNT-1:0] halted, // halted endpoints
  output logic [`MPS_BITS-1:0] final_packet_length // last packet of loaded descriptor
);
  import pipe_resp_pkg::*;

  localparam int RW = $bits(resp_type);

  resp_type head;
  logic head_valid;
  logic head_pop;
  logic out_of_band;
  logic take;
  state_type st_q;
  logic [`EP_BITS-1:0] cur_q;
  logic [`EP_BITS-1:0] rr_q;
  logic [`BUDGET_BITS-1:0] budget_q;
  logic [`SIZE_BITS-1:0] rem_q [`EP_COUNT];
  logic [`SEQ_BITS-1:0] seq_q [`EP_COUNT];
  logic [`BUSERR_BITS-1:0] buserr_q [`EP_COUNT];
  logic [`EP_COUNT-1:0] td_active_q;
  logic [`EP_COUNT-1:0] ready_mask;
  logic [`EP_BITS:0] pick;
  logic multi;
  logic [`SIZE_BITS-1:0] cur_rem;
  logic [`BUSERR_BITS-1:0] cur_buserr;
  logic [`MPS_BITS-1:0] exp_len;
  logic hdr_err;
  logic pay_err;
  logic babble;
  logic short_pkt;
  action_type dec;
  logic bus_hit;
  logic budget_hit;
  logic buserr_reload;
  logic seq_back;
  logic seq_next;
  logic [`MPS_BITS-1:0] consumed;
  logic [`SIZE_BITS-1:0] mps_ext;
  logic [`SIZE_BITS-1:0] fpl_full;

  // first ready endpoint after the last one served, wrapping
  function automatic logic [`EP_BITS:0] next_ep(input logic [`EP_COUNT-1:0] rdy,
                                                input logic [`EP_BITS-1:0] last);
    logic [`EP_BITS-1:0] idx;
    next_ep = '0;
    for (int i = `EP_COUNT; i >= 1; i--) begin
      idx = last + i[`EP_BITS-1:0];
      if (rdy[idx]) begin
        next_ep = {1'b1, idx};
      end
    end
  endfunction

  function automatic logic more_than_one(input logic [`EP_COUNT-1:0] rdy);
    int n;
    n = 0;
    for (int i = 0; i < `EP_COUNT; i++) begin
      n = n + int'(rdy[i]);
    end
    more_than_one = (n > 1);
  endfunction

  // responses queue here so a late decision never loses one
  resp_fifo #(.WIDTH(RW), .DEPTH(`FIFO_DEPTH)) u_queue (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(resp_valid),
    .in_ready(resp_ready),
    .in_data(resp),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head)
  );

  assign ready_mask = sched & ~halted & td_active_q;
  assign pick = next_ep(ready_mask, rr_q);
  assign multi = more_than_one(ready_mask);
  assign cur_rem = rem_q[cur_q];
  assign cur_buserr = buserr_q[cur_q];
  assign exp_len = (cur_rem < mps_ext) ? cur_rem[`MPS_BITS-1:0] : max_packet_size;
  assign hdr_err = head.addr_bad || head.ep_bad || head.seq_bad;
  assign pay_err = head.crc_bad || head.payload_missing || head.retry_flag || head.len_mismatch;
  assign babble = (head.len > max_packet_size) || ({{(`SIZE_BITS-`MPS_BITS){1'b0}}, head.len} > cur_rem);
  assign short_pkt = head.len < exp_len;
  assign out_of_band = head.kind inside {RESP_ERDY, RESP_TP_ERROR, RESP_ACK_ERROR};
  // transaction answers wait until any transaction is outstanding; answers for another endpoint are then discarded
  assign head_pop = head_valid && (out_of_band || st_q == ST_WAIT);
  assign take = head_pop && !out_of_band && head.ep == cur_q;
  assign mps_ext = {{(`SIZE_BITS-`MPS_BITS){1'b0}}, max_packet_size};
  assign fpl_full = (mps_ext == '0) ? '0 : td_size - `SIZE_BITS'(mps_ext * (td_size / mps_ext));

  always_comb begin
    dec = '0;
    dec.valid = head_pop;
    dec.ep = take ? cur_q : head.ep;
    dec.ev = EV_NONE;
    bus_hit = 1'b0;
    budget_hit = 1'b0;
    buserr_reload = 1'b0;
    seq_back = 1'b0;
    seq_next = 1'b0;
    consumed = '0;
    if (head_pop && head.kind == RESP_ERDY) begin
      dec.place = 1'b1;
    end else if (head_pop && !take) begin
      dec.discard = 1'b1;
    end
    if (take) begin
      case (head.kind)
        RESP_DATA: begin
          if (hdr_err) begin
            dec.discard = 1'b1;
          end else if (pay_err) begin
            dec.discard = 1'b1;
            bus_hit = 1'b1;
          end else if (babble) begin
            {dec.discard, dec.halt, dec.pull, dec.advance} = 4'hf;
            dec.ev = EV_BABBLE;
          end else begin
            dec.ack = 1'b1;
            consumed = head.len;
            buserr_reload = 1'b1;
            if (head.eob) begin
              {dec.pull, dec.advance} = 2'h3;
              dec.retire = short_pkt || ({{(`SIZE_BITS-`MPS_BITS){1'b0}}, head.len} == cur_rem);
            end else if (short_pkt || {{(`SIZE_BITS-`MPS_BITS){1'b0}}, head.len} == cur_rem) begin
              {dec.retire, dec.advance} = 2'h3;
            end else begin
              budget_hit = 1'b1;
            end
          end
        end
        RESP_ACK: begin
          consumed = exp_len;
          buserr_reload = 1'b1;
          seq_next = 1'b1;
          if ({{(`SIZE_BITS-`MPS_BITS){1'b0}}, exp_len} == cur_rem) begin
            {dec.retire, dec.advance} = 2'h3;
          end else begin
            budget_hit = 1'b1;
          end
        end
        RESP_ACK_RETRY: begin
          bus_hit = 1'b1;
          seq_back = (cur_buserr > 2'h1);
        end
        RESP_NRDY: {dec.pull, dec.advance} = 2'h3;
        RESP_STALL: begin
          {dec.halt, dec.pull, dec.advance} = 3'h7;
          dec.ev = EV_STALL;
        end
        RESP_TIMEOUT: begin
          {dec.halt, dec.pull, dec.advance} = 3'h7;
          dec.ev = EV_TRANSACTION;
        end
        default: dec.discard = 1'b1;
      endcase
      if (bus_hit) begin
        if (cur_buserr <= 2'h1) begin
          {dec.halt, dec.pull, dec.advance} = 3'h7;
          dec.ev = EV_TRANSACTION;
        end else begin
          budget_hit = 1'b1;
        end
      end
      if (budget_hit) begin
        // a lone endpoint keeps streaming past its budget
        if (budget_q <= `BUDGET_BITS'(1) && multi) begin
          dec.advance = 1'b1;
        end else begin
          dec.cont = 1'b1;
        end
      end
      if (dec.retire && ring_empty[cur_q]) begin
        dec.pull = 1'b1;
      end
    end
  end

  generate
    for (genvar g = 0; g < `EP_COUNT; g++) begin : g_ep
      logic hit;
      assign hit = take && cur_q == g;
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          sched[g] <= 1'b0;
        end else if (td_load && td_ep == g) begin
          sched[g] <= 1'b1;
        end else if (dec.place && head.ep == g) begin
          sched[g] <= 1'b1;
        end else if (hit && dec.pull) begin
          sched[g] <= 1'b0;
        end
      end
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          halted[g] <= 1'b0;
        end else if (hit && dec.halt) begin
          halted[g] <= 1'b1;
        end else if (halt_clear && halt_clear_ep == g) begin
          halted[g] <= 1'b0;
        end
      end
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          buserr_q[g] <= `BUSERR_RELOAD;
        end else if ((hit && buserr_reload) || (halt_clear && halt_clear_ep == g)) begin
          buserr_q[g] <= `BUSERR_RELOAD;
        end else if (hit && bus_hit && buserr_q[g] != '0) begin
          buserr_q[g] <= buserr_q[g] - 1'b1;
        end
      end
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          rem_q[g] <= '0;
          td_active_q[g] <= 1'b0;
        end else if (td_load && td_ep == g) begin
          rem_q[g] <= td_size;
          td_active_q[g] <= 1'b1;
        end else if (hit) begin
          rem_q[g] <= rem_q[g] - {{(`SIZE_BITS-`MPS_BITS){1'b0}}, consumed};
          td_active_q[g] <= td_active_q[g] && !dec.retire;
        end
      end
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          seq_q[g] <= '0;
        end else if (hit && seq_back) begin
          seq_q[g] <= head.seq;
        end else if (hit && seq_next) begin
          seq_q[g] <= seq_q[g] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ST_PICK;
      cur_q <= '0;
      rr_q <= '0;
    end else begin
      case (st_q)
        ST_PICK: begin
          if (pick[`EP_BITS]) begin
            cur_q <= pick[`EP_BITS-1:0];
            st_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: st_q <= ST_WAIT;
        ST_WAIT: begin
          if (take && dec.advance) begin
            rr_q <= cur_q;
            st_q <= ST_PICK;
          end else if (take && dec.cont) begin
            st_q <= ST_ISSUE;
          end
        end
        default: st_q <= ST_PICK;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      budget_q <= `BUDGET_RESET;
    end else if (st_q == ST_PICK && pick[`EP_BITS]) begin
      budget_q <= max_opportunity_packets;
    end else if (take && budget_hit) begin
      budget_q <= (budget_q <= `BUDGET_BITS'(1) && !multi) ? max_opportunity_packets : budget_q - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      request <= '0;
      action <= '0;
      final_packet_length <= '0;
    end else begin
      request.valid <= (st_q == ST_ISSUE);
      request.ep <= cur_q;
      request.dir_in <= ep_dir_in[cur_q];
      request.len <= exp_len;
      request.seq <= seq_q[cur_q];
      action <= dec;
      if (td_load) begin
        final_packet_length <= fpl_full[`MPS_BITS-1:0];
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence good_in;
    take && head.kind == RESP_DATA && !hdr_err && !pay_err && !babble;
  endsequence
  sequence last_bus_error;
    take && bus_hit && cur_buserr <= 2'h1;
  endsequence

  budget_step_a: assert property (good_in ##0 (!head.eob && !short_pkt && head.len != cur_rem && budget_q > 1)
    |=> budget_q == $past(budget_q) - 1 && st_q == ST_ISSUE ##1 request.valid) else $error("budget not stepped");
  short_retire_a: assert property (good_in ##0 (!head.eob && short_pkt)
    |=> action.retire && action.advance && st_q == ST_PICK) else $error("short packet not retired");
  eob_pull_a: assert property (good_in ##0 (head.eob && !td_load)
    |=> !sched[$past(cur_q)] && action.advance) else $error("end of burst not pulled");
  nrdy_pull_a: assert property (take && head.kind == RESP_NRDY && !td_load
    |=> !sched[$past(cur_q)] && action.ev == EV_NONE && !action.halt) else $error("not ready mishandled");
  erdy_place_a: assert property (head_pop && head.kind == RESP_ERDY
    |=> sched[$past(head.ep)] && action.place) else $error("endpoint not placed");
  stall_halt_a: assert property (take && head.kind == RESP_STALL
    |=> halted[$past(cur_q)] && action.ev == EV_STALL && st_q == ST_PICK) else $error("stall not halted");
  buserr_out_a: assert property (last_bus_error
    |=> halted[$past(cur_q)] && action.ev == EV_TRANSACTION) else $error("bus errors exhausted, no halt");
  seq_rewind_a: assert property (take && head.kind == RESP_ACK_RETRY && cur_buserr > 2'h1
    |=> seq_q[$past(cur_q)] == $past(head.seq) && !halted[$past(cur_q)]) else $error("sequence not rewound");
  hdr_drop_a: assert property (take && head.kind == RESP_DATA && hdr_err && !halt_clear
    |=> !action.ack && st_q == ST_WAIT && cur_buserr == $past(cur_buserr)) else $error("header error acted on");
  babble_halt_a: assert property (good_in or (take && head.kind == RESP_DATA && !hdr_err && !pay_err && babble)
    |=> action.ev == EV_BABBLE == $past(babble) && action.halt == $past(babble)) else $error("babble mishandled");
  timeout_halt_a: assert property (take && head.kind == RESP_TIMEOUT && !halt_clear
    |=> action.ev == EV_TRANSACTION && cur_buserr == $past(cur_buserr)) else $error("timeout mishandled");
  ring_pull_a: assert property (take && dec.retire && ring_empty[cur_q] && !td_load
    |=> !sched[$past(cur_q)]) else $error("empty ring not pulled");
  final_len_a: assert property (td_load && max_packet_size != '0
    |=> final_packet_length == $past(td_size) % $past(mps_ext)) else $error("final length wrong");
  budget_load_a: assert property (st_q == ST_PICK && pick[`EP_BITS]
    |=> budget_q == $past(max_opportunity_packets) ##1 request.valid) else $error("budget not reloaded");

endmodule

`default_nettype wire

// ---- rtl/async_pipe_defs.svh ----
// constants for the asynchronous pipe response handler
// assumes inclusion by the package and by the handler; definitions only
`ifndef ASYNC_PIPE_DEFS_SVH
`define ASYNC_PIPE_DEFS_SVH

`define EP_COUNT 8
`define EP_BITS 3
`define MPS_BITS 11
`define SIZE_BITS 17
`define SEQ_BITS 5
`define BUDGET_BITS 5
`define BUSERR_BITS 2
`define BUSERR_RELOAD 2'h3
`define BUDGET_RESET 5'h00
`define FIFO_DEPTH 8

`endif

// ---- rtl/pipe_resp_pkg.sv ----
// types shared by the response handler and its user
// assumes the constants header sits beside it
`include "async_pipe_defs.svh"

package pipe_resp_pkg;

  typedef enum logic [3:0] {
    RESP_DATA, RESP_ACK, RESP_ACK_RETRY, RESP_NRDY, RESP_ERDY,
    RESP_STALL, RESP_TIMEOUT, RESP_TP_ERROR, RESP_ACK_ERROR
  } resp_kind_type;

  typedef enum logic [1:0] {EV_NONE, EV_STALL, EV_TRANSACTION, EV_BABBLE} event_kind_type;

  typedef struct packed {
    resp_kind_type kind;
    logic [`EP_BITS-1:0] ep;
    logic eob;
    logic crc_bad;
    logic payload_missing;
    logic retry_flag;
    logic len_mismatch;
    logic addr_bad;
    logic ep_bad;
    logic seq_bad;
    logic [`MPS_BITS-1:0] len;
    logic [`SEQ_BITS-1:0] seq;
  } resp_type;

  typedef struct packed {
    logic valid;
    logic [`EP_BITS-1:0] ep;
    logic retire;
    logic pull;
    logic place;
    logic halt;
    logic advance;
    logic cont;
    logic discard;
    logic ack;
    event_kind_type ev;
  } action_type;

  typedef struct packed {
    logic valid;
    logic [`EP_BITS-1:0] ep;
    logic dir_in;
    logic [`MPS_BITS-1:0] len;
    logic [`SEQ_BITS-1:0] seq;
  } request_type;

  typedef enum {ST_PICK, ST_ISSUE, ST_WAIT} state_type;

endpackage

// ---- rtl/resp_fifo.sv ----
// small synchronous fifo holding endpoint responses
// assumes a power-of-two depth and a single clock
`timescale 1ns/1ps
`default_nettype none

module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic in_valid, // producer offers a word
  output logic in_ready, // room left, registered
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // consumer takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_q];
  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
      count_q <= count_d;
      // registered so the producer sees a clean level
      in_ready <= (count_d != (AW+1)'(DEPTH));
    end
  end

endmodule

`default_nettype wire

// ---- dv/endpoint_model.sv ----
// behavioural superspeed endpoint answering the handler's transaction requests
// assumes the bench sets the answer template before each request and may inject packets
`timescale 1ns/1ps
`default_nettype none

module endpoint_model (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire pipe_resp_pkg::request_type request, // transaction from the handler
  input wire logic resp_ready, // handler takes the answer
  input wire pipe_resp_pkg::resp_type tmpl, // answer to the next request
  input wire logic [3:0] dly, // answer latency in cycles
  input wire logic inject, // send inj_resp unsolicited
  input wire pipe_resp_pkg::resp_type inj_resp, // unsolicited packet
  output logic resp_valid, // answer offered
  output pipe_resp_pkg::resp_type resp // answer
);
  import pipe_resp_pkg::*;
  resp_type pend [$];
  resp_type r;
  request_type req_q;
  logic armed;
  int wait_n;

  always @(posedge clock) begin
    if (sys_rst) begin
      pend.delete();
      armed <= 1'b0;
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      if (inject) pend.push_back(inj_resp);
      if (request.valid) begin
        req_q <= request;
        armed <= 1'b1;
        wait_n <= int'(dly);
      end else if (armed && wait_n > 0) begin
        wait_n <= wait_n - 1;
      end else if (armed) begin
        r = tmpl;
        r.ep = req_q.ep;
        // a zero template length means a packet of the requested size, keeping the template's flags
        if (tmpl.len == '0) r.len = req_q.len;
        pend.push_back(r);
        armed <= 1'b0;
      end
      if (!resp_valid || resp_ready) begin
        if (pend.size() > 0) begin
          resp <= pend.pop_front();
          resp_valid <= 1'b1;
        end else begin
          // released bus shows no stale packet
          resp_valid <= 1'b0;
          resp <= ~resp;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- dv/async_pipe_handler_tb.sv ----
// self-checking bench for the asynchronous pipe response handler
// assumes the endpoint model beside it; a queue-based reference predicts every action
`timescale 1ns/1ps
`default_nettype none
`include "async_pipe_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end

module async_pipe_handler_tb;
  import pipe_resp_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic resp_valid, resp_ready, td_load = 1'b0, halt_clear = 1'b0, inject = 1'b0;
  resp_type resp, tmpl = '0, inj_resp = '0;
  request_type request;
  action_type action;
  logic [`EP_BITS-1:0] td_ep = '0, halt_clear_ep = '0;
  logic [`SIZE_BITS-1:0] td_size = '0;
  logic [`EP_COUNT-1:0] ring = 8'hff, sched, halted, hx = '0;
  logic [`MPS_BITS-1:0] fpl;
  logic [3:0] dly = '0;
  logic [31:0] st = 32'hf283;
  logic [`SEQ_BITS-1:0] sq [8] = '{default: '0};
  int mps = 64, bud = 4, rem [8] = '{default: 0}, be [8] = '{default: 3};
  int cur, n_act, hchk, cyc, compares, miscompares, i;
  int reqs [$];
  resp_type q [$];

  always #2.5 clock = ~clock;

  async_pipe_handler async_pipe_handler_inst (.clock(clock), .sys_rst(sys_rst), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp(resp), .td_load(td_load), .td_ep(td_ep), .td_size(td_size),
    .halt_clear(halt_clear), .halt_clear_ep(halt_clear_ep), .ep_dir_in(8'h0f), .ring_empty(ring),
    .max_packet_size(mps[`MPS_BITS-1:0]), .max_opportunity_packets(bud[`BUDGET_BITS-1:0]),
    .request(request), .action(action), .sched(sched), .halted(halted), .final_packet_length(fpl));

  endpoint_model endpoint_model_inst (.clock(clock), .sys_rst(sys_rst), .request(request),
    .resp_ready(resp_ready), .tmpl(tmpl), .dly(dly), .inject(inject), .inj_resp(inj_resp),
    .resp_valid(resp_valid), .resp(resp));

  function automatic logic [31:0] rng();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction

  function automatic int mn(int a, int b);
    return a < b ? a : b;
  endfunction

  function automatic resp_type mk(resp_kind_type k, int e, logic [7:0] f, int len, int s = 0);
    mk = '0;
    mk.kind = k;
    mk.ep = e[`EP_BITS-1:0];
    {mk.eob, mk.crc_bad, mk.payload_missing, mk.retry_flag, mk.len_mismatch, mk.addr_bad, mk.ep_bad,
      mk.seq_bad} = f;
    mk.len = len[`MPS_BITS-1:0];
    mk.seq = s[`SEQ_BITS-1:0];
  endfunction

  // bus error counter step; exhaustion reports a transaction error
  function automatic event_kind_type bhit(int e);
    if (be[e] == 1) return EV_TRANSACTION;
    be[e]--;
    return EV_NONE;
  endfunction

  task automatic chk_act(resp_type r);
    int e, xr, xh, xd, xp, xl, xk;
    event_kind_type xe;
    e = r.ep;
    xr = 0; xh = 0; xd = 0; xp = 0; xl = 0; xk = 0; xe = EV_NONE;
    if (r.kind inside {RESP_DATA, RESP_ACK, RESP_ACK_RETRY, RESP_NRDY, RESP_STALL, RESP_TIMEOUT} && e != cur)
      xd = 1;
    else case (r.kind)
      RESP_ERDY: xl = 1;
      RESP_NRDY: xp = 1;
      RESP_STALL: xe = EV_STALL;
      RESP_TIMEOUT: xe = EV_TRANSACTION;
      RESP_DATA: begin
        xd = 1;
        if (r.addr_bad | r.ep_bad | r.seq_bad) xd = 1;
        else if (r.crc_bad | r.payload_missing | r.retry_flag | r.len_mismatch) xe = bhit(e);
        else if (r.len > mps || r.len > rem[e]) xe = EV_BABBLE;
        else begin
          xd = 0;
          xk = 1;
          be[e] = 3;
          rem[e] -= r.len;
          xr = (r.len < mps || rem[e] == 0);
          xp = r.eob;
        end
      end
      RESP_ACK: begin
        be[e] = 3;
        rem[e] -= mn(rem[e], mps);
        sq[e]++;
        xr = (rem[e] == 0);
      end
      RESP_ACK_RETRY: begin
        xe = bhit(e);
        if (xe == EV_NONE) sq[e] = r.seq;
      end
      default: xd = 1;
    endcase
    if (xe != EV_NONE) begin
      xh = 1;
      xp = 1;
      hx[e] = 1'b1;
    end
    if (xr != 0 && ring[e]) xp = 1;
    `CHK("ep", e, action.ep)
    `CHK("retire", xr, action.retire)
    `CHK("pull", xp, action.pull)
    `CHK("place", xl, action.place)
    `CHK("halt", xh, action.halt)
    `CHK("discard", xd, action.discard)
    `CHK("event", xe, action.ev)
    `CHK("ack", xk, action.ack)
    if (xh + xp + xr > 0) `CHK("advance", 1, action.advance)
  endtask

  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      give_verdict();
    end
    if (!sys_rst) begin
      if (resp_valid && resp_ready) q.push_back(resp);
      if (request.valid) begin
        cur = request.ep;
        reqs.push_back(cur);
        `CHK("req_len", mn(rem[cur], mps), request.len)
        if (!request.dir_in) `CHK("req_seq", sq[cur], request.seq)
      end
      if (hchk > 0) begin
        hchk--;
        if (hchk == 0) `CHK("halted", hx, halted)
      end
      if (action.valid) begin
        n_act++;
        hchk = 3;
        if (q.size() == 0) `CHK("queued", 1, 0)
        else chk_act(q.pop_front());
      end
    end
  end

  task automatic step(resp_type t, int n, logic inj = 1'b0, resp_type ij = '0);
    int s, k;
    s = n_act;
    tmpl = t;
    dly = rng() % 8;
    inject = inj;
    inj_resp = ij;
    @(negedge clock) inject = 1'b0;
    for (k = 0; k < 400 && n_act < s + n; k++) @(negedge clock);
    if (n_act < s + n) `CHK("actions", s + n, n_act)
  endtask

  task automatic load(int e, int s);
    td_load = 1'b1;
    td_ep = e[`EP_BITS-1:0];
    td_size = s[`SIZE_BITS-1:0];
    rem[e] = s;
    @(negedge clock) td_load = 1'b0;
    `CHK("residue", s % mps, fpl)
  endtask

  task automatic clr(resp_type t);
    halt_clear = 1'b1;
    halt_clear_ep = 3'h1;
    hx[1] = 1'b0;
    be[1] = 3;
    @(negedge clock) halt_clear = 1'b0;
    step(t, 2, 1'b1, mk(RESP_ERDY, 1, 8'h00, 0));
  endtask

  initial begin
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    // queue filled while nothing waits, then drained as stray discards
    inj_resp = mk(RESP_NRDY, 3, 8'h00, 0);
    inject = 1'b1;
    repeat (10) @(negedge clock);
    inject = 1'b0;
    repeat (12) @(negedge clock);
    `CHK("ready", 1'b0, resp_ready)
    load(2, 64);
    step(mk(RESP_DATA, 2, 8'h00, 0), 11);
    $display("fill test done");
    for (i = 0; i < 6; i++) begin
      mps = 1 + rng() % 2047;
      load(7, 1 + rng() % 131071);
      step(mk(RESP_NRDY, 7, 8'h00, 0), 1);
    end
    $display("residue test done");
    mps = 64;
    load(1, 200);
    for (i = 0; i < 4; i++) step(mk(RESP_DATA, 1, 8'h00, 0), 1);
    load(1, 128);
    step(mk(RESP_DATA, 1, 8'h40, 0), 1);
    step(mk(RESP_DATA, 1, 8'h08, 0), 1);
    step(mk(RESP_DATA, 1, 8'h20, 0), 1);
    clr(mk(RESP_DATA, 1, 8'h10, 0));
    load(1, 256);
    step(mk(RESP_DATA, 1, 8'h04, 0), 1);
    for (i = 0; i < 3; i++)
      step(mk(RESP_DATA, 1, i < 2 ? 8'h02 >> i : 8'h80, 0), 2, 1'b1, mk(RESP_DATA, 1, 8'h00, 64));
    ring = 8'h00;
    load(1, 300);
    step(mk(RESP_DATA, 1, 8'h80, 0), 1);
    step(mk(RESP_DATA, 1, 8'h00, 65), 2, 1'b1, mk(RESP_ERDY, 1, 8'h00, 0));
    clr(mk(RESP_STALL, 1, 8'h00, 0));
    clr(mk(RESP_TIMEOUT, 1, 8'h00, 0));
    step(tmpl, 1, 1'b1, mk(RESP_TP_ERROR, 1, 8'h00, 0));
    step(tmpl, 1, 1'b1, mk(RESP_ACK_ERROR, 1, 8'h00, 0));
    $display("in test done");
    ring = 8'hff;
    load(5, 200);
    step(mk(RESP_ACK, 5, 8'h00, 0), 1);
    step(mk(RESP_ACK, 5, 8'h00, 0), 1);
    step(mk(RESP_ACK_RETRY, 5, 8'h00, 0, 1), 1);
    step(mk(RESP_ACK, 5, 8'h00, 0), 1);
    step(mk(RESP_ACK, 5, 8'h00, 0), 1);
    load(5, 64);
    for (i = 0; i < 3; i++) step(mk(RESP_ACK_RETRY, 5, 8'h00, 0, 2), 1);
    $display("out test done");
    mps = 16;
    bud = 2;
    ring = 8'h00;
    load(4, 160);
    load(6, 160);
    reqs.delete();
    for (i = 0; i < 8; i++) step(mk(RESP_ACK, 4, 8'h00, 0), 1);
    step(mk(RESP_NRDY, 4, 8'h00, 0), 2);
    for (i = 0; i < 4; i++) begin
      `CHK("budget_run", reqs[2 * i], reqs[2 * i + 1])
      `CHK("round_robin", 1'b1, reqs[2 * i + 1] != reqs[2 * i + 2])
    end
    $display("budget test done");
    give_verdict();
  end
endmodule

`default_nettype wire
